/* File: hdl/fws_pkg.sv */
// Package for the flash write-status host controller.
// Assumes an AXI4-Lite master and a parallel NOR flash on the far side.
package fws_pkg;
  // ----------------------------------------
  // Register map (one 32-bit word each)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_RDAT = 8'h10;
  // CTRL fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_ERASE = 1;
  localparam int CTRL_SUSP = 2;
  // STAT fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_RB = 3;
  // Flash status byte bit positions
  localparam int POLL_BIT = 7;
  localparam int TOG1_BIT = 6;
  localparam int FAIL_BIT = 5;
  localparam int TOG2_BIT = 2;
  // Commands and bus responses
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Flash cycle timing
  localparam int T_STROBE_NS = 50;
  localparam int CLK_NS = 5;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01, S_WR = 8'h02, S_RD1 = 8'h04, S_RD2 = 8'h08,
    S_RD3 = 8'h10, S_RST = 8'h20, S_FIN = 8'h40, S_RDA = 8'h80
  } fws_state_t;

  typedef struct packed {
    logic [21:0] addr;
    logic [7:0] dout;
    logic dout_en;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } fws_pins_t;
endpackage

/* File: hdl/fws_host.sv */
// Host controller that runs the write-status polling procedure of a NOR flash.
// Assumes an AXI4-Lite master; the flash answers reads within STROBE_CYC cycles.
// ----------------------------------------
// Summary of operation
// ----------------------------------------
`timescale 1ns/1ps
module fws_host import fws_pkg::*; #(
  parameter int ADDR_W = 22
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [21:0] O_FL_ADDR,
  output logic [7:0] O_FL_DQ,
  output logic O_FL_DQ_OE,
  input wire logic [7:0] I_FL_DQ,
  output logic O_FL_CE_N,
  output logic O_FL_OE_N,
  output logic O_FL_WE_N,
  input wire logic I_FL_READY_BUSY
);
  if (ADDR_W != 22) begin : g_bad_addr_w
    $error("ADDR_W must be 22");
  end
  // ----------------------------------------
  // Registers and bus slave
  // ----------------------------------------
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [21:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic done_r, done_nxt, fail_r, fail_nxt;
  logic [7:0] rdat_r, rdat_nxt;
  logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, ar_r, ar_nxt, rv_r, rv_nxt;
  logic [7:0] awa_r, awa_nxt;
  logic awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
  fws_state_t st_r, st_nxt;
  fws_pins_t pin_r, pin_nxt;
  logic [7:0] cnt_r, cnt_nxt, s1_r, s1_nxt;
  logic rb_r;
  logic busy;
  assign busy = (st_r != S_IDLE);

  always_comb begin
    aw_nxt = aw_r;
    awa_nxt = awa_r;
    w_nxt = w_r;
    wd_nxt = wd_r;
    bv_nxt = bv_r;
    br_nxt = br_r;
    ar_nxt = 1'b0;
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    ctrl_nxt = ctrl_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    if (I_AWVALID && !aw_r && !bv_r) begin
      aw_nxt = 1'b1;
      awa_nxt = I_AWADDR;
    end
    if (I_WVALID && !w_r && !bv_r) begin
      w_nxt = 1'b1;
      wd_nxt = I_WDATA;
    end
    if (aw_r && w_r) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = RESP_OKAY;
      if (awa_r == REG_CTRL) begin
        if (!busy && wd_r[CTRL_GO]) ctrl_nxt = wd_r[2:0];
        else if (busy && wd_r[CTRL_SUSP] && ctrl_r[CTRL_ERASE]) ctrl_nxt[CTRL_SUSP] = 1'b1;
        else br_nxt = RESP_SLVERR;
      end else if (awa_r == REG_ADDR) begin
        addr_nxt = wd_r[21:0];
      end else if (awa_r == REG_DATA) begin
        data_nxt = wd_r[7:0];
      end else begin
        br_nxt = RESP_SLVERR;
      end
    end
    if (bv_r && I_BREADY) bv_nxt = 1'b0;
    if (st_r == S_FIN && (done_r || fail_r)) ctrl_nxt[CTRL_GO] = 1'b0;
    if (st_r == S_WR && cnt_r == 8'h00) ctrl_nxt[CTRL_SUSP] = 1'b0;
    if (I_ARVALID && !ar_r && !rv_r) begin
      ar_nxt = 1'b1;
      rr_nxt = RESP_OKAY;
      if (I_ARADDR == REG_CTRL) rd_nxt = {29'h0, ctrl_r};
      else if (I_ARADDR == REG_ADDR) rd_nxt = {10'h0, addr_r};
      else if (I_ARADDR == REG_DATA) rd_nxt = {24'h0, data_r};
      else if (I_ARADDR == REG_STAT) rd_nxt = {28'h0, rb_r, fail_r, done_r, busy};
      else if (I_ARADDR == REG_RDAT) rd_nxt = {24'h0, rdat_r};
      else begin
        rd_nxt = 32'h0;
        rr_nxt = RESP_SLVERR;
      end
    end
    if (ar_r) rv_nxt = 1'b1; // Answer only after the address handshake
    if (rv_r && I_RREADY) rv_nxt = 1'b0;
    awrdy_nxt = !aw_nxt && !bv_nxt;
    wrdy_nxt = !w_nxt && !bv_nxt;
  end
  // ----------------------------------------
  // Polling sequencer
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    pin_nxt = pin_r;
    cnt_nxt = cnt_r;
    s1_nxt = s1_r;
    done_nxt = done_r;
    fail_nxt = fail_r;
    rdat_nxt = rdat_r;
    if (cnt_r != 8'h00) cnt_nxt = cnt_r - 8'h01;
    case (st_r)
      S_IDLE: begin
        pin_nxt.ce_n = 1'b1;
        pin_nxt.oe_n = 1'b1;
        pin_nxt.we_n = 1'b1;
        pin_nxt.dout_en = 1'b0;
        if (ctrl_r[CTRL_GO] && !bv_r) begin
          pin_nxt.addr = addr_r;
          done_nxt = 1'b0;
          fail_nxt = 1'b0;
          st_nxt = S_RD1;
          cnt_nxt = STROBE_CYC[7:0];
          pin_nxt.ce_n = 1'b0;
          pin_nxt.oe_n = 1'b0;
        end
      end
      S_WR: begin
        if (cnt_r == 8'h00) begin
          pin_nxt.we_n = 1'b1; // Chip select and data held past the strobe
          st_nxt = S_FIN;
        end
      end
      S_RD1, S_RD2, S_RD3, S_RDA: begin
        if (ctrl_r[CTRL_SUSP] && st_r != S_RDA) begin
          pin_nxt.oe_n = 1'b1;
          pin_nxt.dout = CMD_SUSPEND;
          pin_nxt.dout_en = 1'b1;
          pin_nxt.we_n = 1'b0;
          cnt_nxt = STROBE_CYC[7:0];
          st_nxt = S_WR;
        end else if (cnt_r == 8'h00 && pin_r.oe_n) begin
          pin_nxt.oe_n = 1'b0; // Gap between reads lets the device toggle
          cnt_nxt = STROBE_CYC[7:0];
        end else if (cnt_r == 8'h00) begin
          pin_nxt.oe_n = 1'b1;
          cnt_nxt = STROBE_CYC[7:0];
          s1_nxt = I_FL_DQ;
          if (st_r == S_RD1) st_nxt = S_RD2;
          else if (st_r == S_RDA) begin
            rdat_nxt = I_FL_DQ;
            done_nxt = 1'b1;
            st_nxt = S_FIN;
          end else if (I_FL_DQ[TOG1_BIT] == s1_r[TOG1_BIT]) st_nxt = S_RDA;
          else if (I_FL_DQ[FAIL_BIT] && st_r == S_RD3) begin
            fail_nxt = 1'b1;
            pin_nxt.oe_n = 1'b1;
            pin_nxt.dout = CMD_RESET;
            pin_nxt.dout_en = 1'b1;
            pin_nxt.we_n = 1'b0;
            st_nxt = S_WR;
          end else if (I_FL_DQ[FAIL_BIT]) st_nxt = S_RD3;
          else st_nxt = S_RD2;
        end
      end
      S_FIN: begin
        pin_nxt.dout_en = 1'b0;
        pin_nxt.ce_n = 1'b1;
        pin_nxt.oe_n = 1'b1;
        if (ctrl_r[CTRL_GO] && !done_r && !fail_r) begin
          st_nxt = S_RD1; // Resume after a suspend write
          pin_nxt.ce_n = 1'b0;
          pin_nxt.oe_n = 1'b0;
          cnt_nxt = STROBE_CYC[7:0];
        end else st_nxt = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ctrl_r <= 3'h0;
      addr_r <= 22'h0;
      data_r <= 8'h0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      rdat_r <= 8'h0;
      aw_r <= 1'b0;
      awa_r <= 8'h0;
      w_r <= 1'b0;
      wd_r <= 32'h0;
      bv_r <= 1'b0;
      br_r <= 2'h0;
      ar_r <= 1'b0;
      rv_r <= 1'b0;
      rd_r <= 32'h0;
      rr_r <= 2'h0;
      st_r <= S_IDLE;
      pin_r <= '{addr: 22'h0, dout: 8'h0, dout_en: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      cnt_r <= 8'h0;
      s1_r <= 8'h0;
      rb_r <= 1'b1;
      awrdy_r <= 1'b1;
      wrdy_r <= 1'b1;
    end else begin
      ctrl_r <= ctrl_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      rdat_r <= rdat_nxt;
      aw_r <= aw_nxt;
      awa_r <= awa_nxt;
      w_r <= w_nxt;
      wd_r <= wd_nxt;
      bv_r <= bv_nxt;
      br_r <= br_nxt;
      ar_r <= ar_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
      rr_r <= rr_nxt;
      st_r <= st_nxt;
      pin_r <= pin_nxt;
      cnt_r <= cnt_nxt;
      s1_r <= s1_nxt;
      rb_r <= I_FL_READY_BUSY;
      awrdy_r <= awrdy_nxt;
      wrdy_r <= wrdy_nxt;
    end
  end

  assign O_AWREADY = awrdy_r;
  assign O_WREADY = wrdy_r;
  assign O_BVALID = bv_r;
  assign O_BRESP = br_r;
  assign O_ARREADY = ar_r;
  assign O_RVALID = rv_r;
  assign O_RDATA = rd_r;
  assign O_RRESP = rr_r;
  assign O_FL_ADDR = pin_r.addr;
  assign O_FL_DQ = pin_r.dout;
  assign O_FL_DQ_OE = pin_r.dout_en;
  assign O_FL_CE_N = pin_r.ce_n;
  assign O_FL_OE_N = pin_r.oe_n;
  assign O_FL_WE_N = pin_r.we_n;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_fail_reset;
    @(posedge I_CLK) disable iff (I_SYS_RST) $rose(fail_r) |-> !O_FL_WE_N && O_FL_DQ == CMD_RESET;
  endproperty
  a_fail_reset: assert property (p_fail_reset) else $error("no reset after failure");
  property p_no_drive_read;
    @(posedge I_CLK) disable iff (I_SYS_RST) !O_FL_OE_N |-> !O_FL_DQ_OE && O_FL_WE_N;
  endproperty
  a_no_drive_read: assert property (p_no_drive_read) else $error("bus clash");
  property p_done_two_reads;
    @(posedge I_CLK) disable iff (I_SYS_RST) $rose(done_r) |-> $past(st_r) == S_RDA;
  endproperty
  a_done_two_reads: assert property (p_done_two_reads) else $error("done without data read");
  property p_susp_erase;
    @(posedge I_CLK) disable iff (I_SYS_RST) $rose(ctrl_r[CTRL_SUSP]) |-> ctrl_r[CTRL_ERASE];
  endproperty
  a_susp_erase: assert property (p_susp_erase) else $error("suspend outside erase");
  property p_fail_recheck;
    @(posedge I_CLK) disable iff (I_SYS_RST) $rose(fail_r) |-> $past(st_r) == S_RD3;
  endproperty
  a_fail_recheck: assert property (p_fail_recheck) else $error("fail without recheck");
  property p_start_double;
    @(posedge I_CLK) disable iff (I_SYS_RST) $past(st_r) == S_IDLE && st_r != S_IDLE |-> st_r == S_RD1;
  endproperty
  a_start_double: assert property (p_start_double) else $error("start skipped first read");
  property p_addr_hold;
    @(posedge I_CLK) disable iff (I_SYS_RST) st_r == S_RD2 |-> $stable(O_FL_ADDR);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("poll address moved");
  property p_rb_follow;
    @(posedge I_CLK) disable iff (I_SYS_RST) ##1 rb_r == $past(I_FL_READY_BUSY);
  endproperty
  a_rb_follow: assert property (p_rb_follow) else $error("ready busy not tracked");
  c_done: cover property (@(posedge I_CLK) $rose(done_r));
  c_fail: cover property (@(posedge I_CLK) $rose(fail_r));
  c_susp: cover property (@(posedge I_CLK) st_r == S_WR && O_FL_DQ == CMD_SUSPEND);
endmodule // fws_host

/* File: bench/fws_flash_model.sv */
// Behavioural flash that answers status reads while an algorithm runs.
// Assumes the bench starts each algorithm through i_go; no clock of its own.
`timescale 1ns/1ps
module fws_flash_model import fws_pkg::*; (
  input wire logic i_go,
  input wire logic i_erase,
  input wire logic i_fail,
  input wire logic [7:0] i_len,
  input wire logic [7:0] i_pdata,
  input wire logic [7:0] i_arr,
  input wire logic [7:0] i_dq,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  output logic [7:0] o_dq,
  output logic o_rb_oe,
  output int o_n_rst,
  output int o_n_susp
);
  // ----------------------------------------
  // Status engine
  // ----------------------------------------
  logic busy = 1'b0;
  logic susp = 1'b0;
  logic ers = 1'b0;
  logic tog1 = 1'b0;
  logic tog2 = 1'b0;
  logic tmo = 1'b0;
  int cnt = 0;
  logic rd_en;
  assign rd_en = !i_ce_n && !i_oe_n;
  initial begin
    o_dq = 8'h00;
    o_n_rst = 0;
    o_n_susp = 0;
  end
  assign o_rb_oe = busy && !susp;
  // Short read counts stand in for the protected busy windows
  always @(posedge i_go) begin
    busy = 1'b1;
    susp = 1'b0;
    tmo = 1'b0;
    ers = i_erase;
    cnt = i_len;
  end
  // One combined enable, so strobes that move together count once
  always @(posedge rd_en) begin
    if (busy) begin
      tog1 = tog1 ^ !susp;
      tog2 = tog2 ^ ers;
      tmo = i_fail && cnt == 0;
      o_dq = {susp | (!ers & ~i_pdata[7]), tog1, tmo, 2'b00, tog2, 2'b00};
      if (cnt > 0 && !susp) cnt--;
      else if (!i_fail && !susp) busy = 1'b0;
    end else begin
      o_dq = i_arr;
    end
  end
  // Released bus flips so a stale byte never passes for data
  always @(negedge rd_en) o_dq = ~o_dq;
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_dq === CMD_RESET) begin
      busy = 1'b0;
      o_n_rst++;
    end
    if (!i_ce_n && i_dq === CMD_SUSPEND && busy && ers) begin
      susp = 1'b1;
      o_n_susp++;
    end
  end
endmodule // fws_flash_model

/* File: bench/tb_top.sv */
// Self-checking bench for the write-status host controller.
// Assumes the flash model on the far side; software side is AXI4-Lite.
`timescale 1ns/1ps
module tb_top import fws_pkg::*;;
  // ----------------------------------------
  // Signals, instances, monitor
  // ----------------------------------------
  logic clk;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, len = 8'h00, pd = 8'h00, arr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic go = 1'b0, ers = 1'b0, fl = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, dq_oe, ce_n, oe_n, we_n, rb_oe;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [21:0] fl_a;
  logic [7:0] dq_o, m_dq, fl_dq;
  int n_rst, n_susp;
  int bad_count = 0, compares = 0, cyc = 0, seed = 32'h6DFE;
  logic [1:0] exp_b[$];
  logic [65:0] exp_r[$];
  assign fl_dq = dq_oe ? dq_o : m_dq;
  fws_host i_dut (.I_CLK(clk), .I_SYS_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .O_FL_ADDR(fl_a), .O_FL_DQ(dq_o), .O_FL_DQ_OE(dq_oe),
    .I_FL_DQ(fl_dq), .O_FL_CE_N(ce_n), .O_FL_OE_N(oe_n), .O_FL_WE_N(we_n), .I_FL_READY_BUSY(!rb_oe));
  fws_flash_model i_mdl (.i_go(go), .i_erase(ers), .i_fail(fl), .i_len(len), .i_pdata(pd), .i_arr(arr),
    .i_dq(fl_dq), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .o_dq(m_dq), .o_rb_oe(rb_oe),
    .o_n_rst(n_rst), .o_n_susp(n_susp));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    logic [65:0] e;
    if (bvalid === 1'b1 && bready && exp_b.size() > 0) chk("bresp", {30'h0, bresp}, {30'h0, exp_b.pop_front()});
    if (rvalid === 1'b1 && rready && exp_r.size() > 0) begin
      e = exp_r.pop_front();
      chk("rdata", rdata & e[65:34], e[33:2]);
      chk("rresp", {30'h0, rresp}, {30'h0, e[1:0]});
    end
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Bus tasks and scenarios
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w, b;
    exp_b.push_back(r);
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w || !b) begin
      @(posedge clk);
      if (!aw && !w && bvalid === 1'b1) b = 1'b1;
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r,
                    output logic [31:0] q);
    logic ar, got;
    exp_r.push_back({m, e, r});
    ar = 1'b1;
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (ar || !got) begin
      @(posedge clk);
      if (rvalid === 1'b1) got = 1'b1;
      if (rvalid === 1'b1) q = rdata;
      if (ar && arready === 1'b1) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic start(input logic e, input logic f, input logic [7:0] l);
    ers <= e;
    fl <= f;
    len <= l;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  // Bounded poll; a hang ends it after 400 reads and is caught by the status check that follows
  task automatic wait_idle();
    logic [31:0] q;
    q = 32'h1;
    for (int n = 0; n < 400 && q[ST_BUSY] !== 1'b0; n++) rd(REG_STAT, 32'h0, 32'h0, RESP_OKAY, q);
  endtask
  initial begin
    logic [31:0] a, p, q;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(REG_STAT, 32'hF, 32'h8, RESP_OKAY, q);
    rd(8'h20, 32'hFFFFFFFF, 32'h0, RESP_SLVERR, q);
    wr(8'h24, 32'h0, RESP_SLVERR);
    wr(REG_CTRL, 32'h4, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      a = $random(seed);
      p = $random(seed);
      pd <= p[7:0];
      arr <= {p[7], a[30:24]};
      wr(REG_ADDR, {10'h0, a[21:0]}, RESP_OKAY);
      rd(REG_ADDR, 32'h3FFFFF, {10'h0, a[21:0]}, RESP_OKAY, q);
      wr(REG_DATA, p, RESP_OKAY);
      rd(REG_DATA, 32'hFF, {24'h0, p[7:0]}, RESP_OKAY, q);
      start(1'b0, 1'b0, 8'(3 * i));
      wr(REG_CTRL, 32'h1, RESP_OKAY);
      wait_idle();
      chk("fl_addr", {10'h0, fl_a}, {10'h0, a[21:0]});
      rd(REG_STAT, 32'h6, 32'h2, RESP_OKAY, q);
      rd(REG_RDAT, 32'hFF, {24'h0, p[7], a[30:24]}, RESP_OKAY, q);
    end
    start(1'b1, 1'b0, 8'h3C);
    wr(REG_CTRL, 32'h3, RESP_OKAY);
    rd(REG_STAT, 32'h9, 32'h1, RESP_OKAY, q);
    wr(REG_CTRL, 32'h4, RESP_OKAY);
    wait_idle();
    rd(REG_STAT, 32'hE, 32'hA, RESP_OKAY, q);
    chk("suspend_cmds", n_susp, 32'h1);
    start(1'b0, 1'b1, 8'h02);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    wait_idle();
    rd(REG_STAT, 32'hC, 32'hC, RESP_OKAY, q);
    chk("reset_cmds", n_rst, 32'h1);
    stop_test();
  end
endmodule // tb_top
